// ===== mipm_mac_model.sv
// Behavioural MAC facing the pin multiplexer.
// Assumes the bench resolves the shared light pin from the device's output enable.
module mipm_mac_model (
  // Control from the bench
  input  wire logic       run,
  input  wire logic [3:0] txd,
  input  wire logic       tx_er,
  // Toward the device
  output logic            crystal_clock_input,
  output logic [3:0]      txd_pin_i,
  output logic            light_drive
);
  timeunit 1ns;
  timeprecision 100ps;
  initial crystal_clock_input = 1'b0;
  // Free-running reference; run low models a lost clock
  always #80 if (run) crystal_clock_input = ~crystal_clock_input;
  assign txd_pin_i   = txd;
  assign light_drive = tx_er;
endmodule : mipm_mac_model

// ===== mipm_monitor.sv
// Port checks for the MAC interface pin multiplexer.
// Bound into mipm_top by the bench; one clock domain.
module mipm_monitor (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      resetn,
  // Core side
  input wire logic                      core_int_n,
  input wire logic                      core_clock,
  input wire logic                      core_crs,
  input wire logic                      core_rx_er,
  input wire logic [3:0]                core_rxd,
  input wire logic [1:0]                core_mac_mode,
  input wire logic                      core_eee_adv,
  input wire logic [3:0]                core_txd,
  // Shared pins
  input wire mipm_pkg::mipm_pin_t       indicator_light_pin,
  input wire mipm_pkg::mipm_pin_t       int_pin,
  input wire mipm_pkg::mipm_pin_t       general_clock_output,
  input wire mipm_pkg::mipm_pin_t [3:0] rxd_pin,
  input wire mipm_pkg::mipm_pin_t       rx_clk_pin,
  input wire mipm_pkg::mipm_pin_t       tx_clk_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire mii  = core_mac_mode == 2'h1;
  wire rmii = core_mac_mode == 2'h2;
  wire eee  = core_eee_adv;
  chk_crs_on_int: assert property (
    mii && !eee |=> int_pin == {$past(core_crs), 1'b1})
    else $error("int pin does not carry carrier sense");
  chk_rx_er_out: assert property (
    mii || rmii |=> general_clock_output == {$past(core_rx_er), 1'b1})
    else $error("receive error not on its pin");
  // Sampled resetn keeps the release edge out: the pins still hold reset
  chk_gp_clock: assert property (
    resetn && !mii && !rmii |=>
      general_clock_output == {$past(core_clock), 1'b1})
    else $error("general clock output not driven");
  chk_eee_int: assert property (
    mii && eee |=> int_pin == {1'b0, !$past(core_int_n)})
    else $error("int pin left its interrupt function");
  chk_eee_nocol: assert property (
    mii && eee |=> !indicator_light_pin.oe)
    else $error("light pin driven while it is an input");
  chk_rmii_idle: assert property (
    rmii |=> !rxd_pin[3].oe && !rxd_pin[2].oe && !rx_clk_pin.oe
             && !tx_clk_pin.oe)
    else $error("unused lane or clock driven in reduced mode");
  chk_rxd_lane: assert property (
    resetn |=> rxd_pin[0] == {$past(core_rxd[0]), 1'b1})
    else $error("receive lane zero does not follow core");
  chk_rmii_txd: assert property (
    rmii && $past(rmii) |-> core_txd[3:2] == 2'h0)
    else $error("upper transmit lanes passed in reduced mode");
endmodule : mipm_monitor

// ===== mipm_pkg.sv
// Constants and types for the MAC interface pin multiplexer.
// Assumes a single 250 MHz clock domain.
package mipm_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control register fields and reset value
  localparam int          CTRL_LED_OVR_BIT = 0;
  localparam int          CTRL_LED_FN_LSB  = 1;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // Status register fields
  localparam int STAT_MODE_LSB  = 0;
  localparam int STAT_EEE_BIT   = 2;
  localparam int STAT_MDIX_LSB  = 3;
  localparam int STAT_REFCK_BIT = 5;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Reference clock loss timeout
  localparam int REFCK_TIMEOUT_NS = 1000;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int REFCK_TIMEOUT_CYC = REFCK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] REFCK_TIMEOUT = 8'(REFCK_TIMEOUT_CYC - 1);

  // MAC interface as selected by the straps
  typedef enum logic [1:0] {
    MAC_RGMII = 2'h0,
    MAC_MII   = 2'h1,
    MAC_RMII  = 2'h2,
    MAC_RSVD  = 2'h3
  } mipm_mac_t;

  // Function carried by the indicator light pin
  typedef enum logic [1:0] {
    LED_FN_LIGHT = 2'h0,
    LED_FN_COL   = 2'h1,
    LED_FN_TXER  = 2'h2,
    LED_FN_RSVD  = 2'h3
  } mipm_led_fn_t;

  // One two-way pin as seen from the device
  typedef struct packed {
    logic o;
    logic oe;
  } mipm_pin_t;

endpackage : mipm_pkg

// ===== mipm_top.sv
// MAC interface pin multiplexer with an AXI4-Lite register slave.
// Assumes PHY core signals arrive on clk; pins and straps do not.
// Contract
// R1: In MII and RMII, receive error drives high to flag a receive error.
// R2: In RGMII the receive-error pin carries the general clock output.
// R3: Crossover strap is a four-level input setting automatic crossover.
// R4: Pins unused by the selected mode keep their first function.
// R5: MII without EEE: collision on light pin, carrier on int pin.
// R6: MII with EEE: light pin is transmit error input; int pin stays int.
// R7: MII pin assignment follows the EEE strap captured at configuration.
// R8: With EEE enabled no carrier sense or collision is driven.
// R9: In RMII the far side supplies a steady 50 MHz reference clock; the MAC model toggles every 80 ns, and the device checks only for edges.
// R10: Software may override the light pin function after configuration.
// R11: RMII uses two low data lanes only; upper lanes and clocks idle.
//
// Our own choices: the AXI4-Lite slave port and the address map.
module mipm_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Strap pins, sampled once after reset
  input  wire logic [1:0]  mac_sel_strap,
  input  wire logic        eee_strap,
  input  wire logic [1:0]  crossover_mode_strap,
  // PHY core sources
  input  wire logic        core_light,
  input  wire logic        core_int_n,
  input  wire logic        core_clock,
  input  wire logic        core_col,
  input  wire logic        core_crs,
  input  wire logic        core_rx_er,
  input  wire logic [3:0]  core_rxd,
  input  wire logic        core_rx_clk,
  input  wire logic        core_tx_clk,
  // PHY core sinks
  output logic [1:0]       core_mac_mode,
  output logic             core_eee_adv,
  output logic [1:0]       core_crossover,
  output logic             core_tx_er,
  output logic [3:0]       core_txd,
  // Shared pins
  input  wire logic        indicator_light_pin_i,
  output mipm_pkg::mipm_pin_t indicator_light_pin,
  output mipm_pkg::mipm_pin_t int_pin,
  output mipm_pkg::mipm_pin_t general_clock_output,
  output mipm_pkg::mipm_pin_t [3:0] rxd_pin,
  output mipm_pkg::mipm_pin_t rx_clk_pin,
  output mipm_pkg::mipm_pin_t tx_clk_pin,
  input  wire logic [3:0]  txd_pin_i,
  input  wire logic        crystal_clock_input
);

  // Pin synchronisers
  logic [1:0] sel_s1, sel_s2, mdx_s1, mdx_s2;
  logic       eee_s1, eee_s2, led_s1, led_s2, rck_s1, rck_s2, rck_s3;
  logic [3:0] txd_s1, txd_s2;

  always_ff @(posedge clk)
  begin
    sel_s1 <= mac_sel_strap;
    sel_s2 <= sel_s1;
    mdx_s1 <= crossover_mode_strap;
    mdx_s2 <= mdx_s1;
    eee_s1 <= eee_strap;
    eee_s2 <= eee_s1;
    led_s1 <= indicator_light_pin_i;
    led_s2 <= led_s1;
    txd_s1 <= txd_pin_i;
    txd_s2 <= txd_s1;
    rck_s1 <= crystal_clock_input;
    rck_s2 <= rck_s1;
    rck_s3 <= rck_s2;
  end

  // Strap capture; a two-cycle wait lets the synchronisers fill
  logic [1:0]          cap_cnt_q;
  mipm_pkg::mipm_mac_t mode_q;
  logic                eee_q;
  logic [1:0]          mdix_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cap_cnt_q <= 2'h0;
      mode_q    <= mipm_pkg::MAC_RGMII;
      eee_q     <= 1'b0;
      mdix_q    <= 2'h0;
    end
    else if (cap_cnt_q != 2'h3)
    begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == 2'h2)
      begin
        mode_q <= mipm_pkg::mipm_mac_t'(sel_s2);
        eee_q  <= eee_s2;                          // [R7]
        mdix_q <= mdx_s2;                          // [R3]
      end
    end
  end

  // Reference clock activity; informs software in RMII
  logic [7:0] rck_cnt_q;
  logic       rck_alive_q;
  wire        rck_rise = rck_s2 & ~rck_s3;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rck_cnt_q   <= 8'h00;
      rck_alive_q <= 1'b0;
    end
    else if (rck_rise)
    begin
      rck_cnt_q   <= 8'h00;
      rck_alive_q <= 1'b1;                         // [R9]
    end
    else if (rck_cnt_q == mipm_pkg::REFCK_TIMEOUT)
      rck_alive_q <= 1'b0;
    else
      rck_cnt_q <= rck_cnt_q + 8'h01;
  end

  // AXI4-Lite write path
  logic        aw_q, w_q, bvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  logic [31:0] ctrl_q;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire do_wr   = aw_q & w_q & ~bvalid_q;
  wire wr_ctrl = awaddr_q == mipm_pkg::CTRL_OFS;
  wire wr_hit  = wr_ctrl | (awaddr_q == mipm_pkg::STATUS_OFS);

  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready  = ~w_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= mipm_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? mipm_pkg::RESP_OKAY : mipm_pkg::RESP_DECERR;
      end
      else if (bvalid_q & s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Control register; only the light pin fields are writable
  always_ff @(posedge clk)
  begin
    if (!resetn)
      ctrl_q <= mipm_pkg::CTRL_RESET;
    else if (do_wr & wr_ctrl & wstrb_q[0])
      ctrl_q[2:0] <= wdata_q[2:0];                 // [R10]
  end

  // AXI4-Lite read path
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  wire         ar_take = s_axi_arvalid & s_axi_arready;
  wire [31:0]  status_w = {26'h0, rck_alive_q, mdix_q, eee_q, mode_q};
  wire         rd_ctrl = s_axi_araddr == mipm_pkg::CTRL_OFS;
  wire         rd_stat = s_axi_araddr == mipm_pkg::STATUS_OFS;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= mipm_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_ctrl ? ctrl_q : (rd_stat ? status_w : 32'h0000_0000);
      rresp_q  <= (rd_ctrl | rd_stat) ? mipm_pkg::RESP_OKAY
                                      : mipm_pkg::RESP_DECERR;
    end
    else if (rvalid_q & s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Pin function selection
  wire is_mii  = mode_q == mipm_pkg::MAC_MII;
  wire is_rmii = mode_q == mipm_pkg::MAC_RMII;
  wire mii_eee = is_mii & eee_q;                   // [R7]
  wire mii_std = is_mii & ~eee_q;

  wire mipm_pkg::mipm_led_fn_t led_strap_fn =
    mii_std ? mipm_pkg::LED_FN_COL :               // [R5]
    mii_eee ? mipm_pkg::LED_FN_TXER :              // [R6]
              mipm_pkg::LED_FN_LIGHT;              // [R4]
  wire mipm_pkg::mipm_led_fn_t led_fn =
    ctrl_q[mipm_pkg::CTRL_LED_OVR_BIT]
      ? mipm_pkg::mipm_led_fn_t'(ctrl_q[mipm_pkg::CTRL_LED_FN_LSB +: 2])
      : led_strap_fn;                              // [R10]

  // Collision only without EEE, even under override
  wire led_col  = (led_fn == mipm_pkg::LED_FN_COL) & ~eee_q;   // [R8]
  wire led_txer = led_fn == mipm_pkg::LED_FN_TXER;
  wire rx_er_on = is_mii | is_rmii;                            // [R1]

  // Registered pin drive
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      indicator_light_pin  <= '0;
      int_pin              <= '0;
      general_clock_output <= '0;
      rxd_pin              <= '0;
      rx_clk_pin           <= '0;
      tx_clk_pin           <= '0;
      core_tx_er           <= 1'b0;
      core_txd             <= 4'h0;
    end
    else
    begin
      indicator_light_pin.o  <= led_col ? core_col : core_light;
      indicator_light_pin.oe <= ~led_txer;                      // [R6]
      // Carrier sense replaces the open-drain interrupt only in MII std
      int_pin.o  <= mii_std ? core_crs : 1'b0;                  // [R5]
      int_pin.oe <= mii_std ? 1'b1 : ~core_int_n;               // [R4] [R8]
      general_clock_output.o  <= rx_er_on ? core_rx_er          // [R1]
                                          : core_clock;         // [R2]
      general_clock_output.oe <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        rxd_pin[i].o  <= core_rxd[i];
        rxd_pin[i].oe <= (i < 2) | ~is_rmii;                    // [R11]
      end
      rx_clk_pin.o  <= core_rx_clk;
      rx_clk_pin.oe <= ~is_rmii;                                // [R11]
      // Transmit clock is an output of the device in MII only
      tx_clk_pin.o  <= core_tx_clk;
      tx_clk_pin.oe <= is_mii;                                  // [R11]
      core_tx_er <= led_txer & led_s2;                          // [R6]
      core_txd   <= is_rmii ? {2'h0, txd_s2[1:0]} : txd_s2;     // [R11]
    end
  end

  assign core_mac_mode  = mode_q;
  assign core_eee_adv   = eee_q;
  assign core_crossover = mdix_q;                               // [R3]

endmodule : mipm_top

// ===== tb.sv
// Bench for the MAC interface pin multiplexer.
// Assumes mipm_top, its package, the MAC model and the checker.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, run = 1, tx_er = 1, light_drive;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, core_txd, txd_pin_i;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_mac_mode, core_crossover;
  logic [1:0] mac_sel_strap = 0, crossover_mode_strap = 0;
  logic eee_strap = 0, core_eee_adv, core_tx_er;
  logic crystal_clock_input, indicator_light_pin_i;
  logic [11:0] src = 0;
  mipm_pkg::mipm_pin_t indicator_light_pin, int_pin, general_clock_output;
  mipm_pkg::mipm_pin_t rx_clk_pin, tx_clk_pin;
  mipm_pkg::mipm_pin_t [3:0] rxd_pin;
  int errors = 0, checks = 0;
  always #2 clk = ~clk;
  // Counting source makes every core input move and its past computable
  always @(posedge clk) src <= src + 12'h1;
  assign indicator_light_pin_i = indicator_light_pin.oe ?
                                 indicator_light_pin.o : light_drive;
  mipm_top mipm_top_inst (.*, .core_light(src[0]), .core_int_n(src[1]),
    .core_clock(src[2]), .core_col(src[3]), .core_crs(src[4]),
    .core_rx_er(src[5]), .core_rxd(src[9:6]), .core_rx_clk(src[10]),
    .core_tx_clk(src[11]));
  // Asymmetric pattern so a mirrored lane order, or a lane swapped with lane one, shows up
  mipm_mac_model mipm_mac_model_inst (.*, .txd(4'hD));
  task automatic results;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic cmp(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  // One AXI4-Lite write or read; d is write data or expected read data
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tr, fin;
    logic [31:0] q;
    logic [1:0] rs;
    fin = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    for (int n = 0; n < 64 && !fin; n++)
    begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      fin = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      rs = we ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
      if (fin) s_axi_bready <= 0;
      if (fin) s_axi_rready <= 0;
    end
    if (!fin)
    begin
      errors++;
      results();
    end
    else
    begin
      cmp("resp", 32'(er), 32'(rs));
      if (!we)
        cmp("rdata", d, q);
    end
  endtask : bus
  task automatic cfg(input logic [1:0] m, x, input logic e);
    @(posedge clk);
    resetn <= 0;
    mac_sel_strap <= m;
    eee_strap <= e;
    crossover_mode_strap <= x;
    repeat (16) @(posedge clk);
    resetn <= 1;
    // Straps settle at the third edge; then at least one clock edge seen
    repeat (60) @(posedge clk);
  endtask : cfg
  // lf: light pin role, 0 light, 1 collision, 2 transmit error input
  task automatic pins(input logic [1:0] m, lf, input logic e);
    logic [11:0] p;
    logic [13:0] x;
    repeat (6) @(posedge clk);
    @(negedge clk);
    p = src - 12'h1;
    x[13:12] = lf == 2 ? 2'h0 : {lf == 1 ? p[3] : p[0], 1'b1};
    x[11:10] = m == 1 && !e ? {p[4], 1'b1} : {1'b0, !p[1]};
    // The reserved select code behaves as the first interface
    x[9:8] = {(m == 1 || m == 2) ? p[5] : p[2], 1'b1};
    x[7:4] = {m != 2, m != 2, m == 1, lf == 2 && tx_er};
    x[3:0] = m == 2 ? 4'h1 : 4'hD;
    cmp("pins", 32'(x), 32'({indicator_light_pin.o & indicator_light_pin.oe,
        indicator_light_pin.oe, int_pin, general_clock_output,
        rxd_pin[3].oe, rx_clk_pin.oe, tx_clk_pin.oe, core_tx_er,
        core_txd}));
    cmp("lanes", 32'({p[11:6], m != 2, 2'h3}), 32'({tx_clk_pin.o,
        rx_clk_pin.o, rxd_pin[3].o, rxd_pin[2].o, rxd_pin[1].o,
        rxd_pin[0].o, rxd_pin[2].oe, rxd_pin[1].oe, rxd_pin[0].oe}));
  endtask : pins
  initial
  begin
    logic [1:0]  m, xm, lf;
    logic        e;
    logic [31:0] st;
    // Every select code, including the reserved one, with both EEE settings
    for (int i = 0; i < 8; i++)
    begin
      m  = 2'(i / 2);
      xm = 2'(i % 4);
      e  = i[0];
      lf = i == 3 ? 2'h2 : {1'b0, i == 2};
      st = {26'h0, 1'b1, xm, e, m};
      cfg(m, xm, e);
      pins(m, lf, e);
      cmp("xover", 32'(xm), 32'(core_crossover));
      cmp("mode", 32'(m), 32'(core_mac_mode));
      cmp("eee", 32'(e), 32'(core_eee_adv));
      bus(1'b0, mipm_pkg::STATUS_OFS, st, 2'h0);
    end
    cfg(2'h0, 2'h0, 1'b0);
    bus(0, mipm_pkg::CTRL_OFS, 32'h0, 2'h0);
    bus(1, mipm_pkg::CTRL_OFS, 32'h3, 2'h0);
    pins(2'h0, 2'h1, 1'b0);
    bus(1, mipm_pkg::CTRL_OFS, 32'h5, 2'h0);
    pins(2'h0, 2'h2, 1'b0);
    bus(0, mipm_pkg::CTRL_OFS, 32'h5, 2'h0);
    // Low level on the released light pin must reach the core as no error
    tx_er <= 1'b0;
    pins(2'h0, 2'h2, 1'b0);
    bus(1, mipm_pkg::STATUS_OFS, 32'hFFFFFFFF, 2'h0);
    bus(0, mipm_pkg::STATUS_OFS, 32'h20, 2'h0);
    bus(1, 8'h08, 32'h1, mipm_pkg::RESP_DECERR);
    bus(0, 8'h08, 32'h0, mipm_pkg::RESP_DECERR);
    run <= 0;
    repeat (300) @(posedge clk);
    bus(0, mipm_pkg::STATUS_OFS, 32'h0, 2'h0);
    results();
  end
endmodule : tb
bind mipm_top mipm_monitor mipm_monitor_inst (.*);
